// ==== design/ccf_core.sv ====
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "ccf_map.svh"
// How it works
// - call only when all listed conditions hold
// - taken call pushes pc+2, loads target
// - taken 4 cycles, not taken 2
// - two prefetched words dropped on discontinuity
// - clear at most one control bit, one cycle
// - mask, saturate in word zero; rest word one
// - test flag is bit 11 of word one
// - invert accumulator, carry and flags untouched
// - compare code picks equal, less, greater, unequal
// - test flag gets unsigned compare result
// - compare ignores and keeps sign fill bit
// - external move target is read only
// - idle bumps pc once then halts
// - peripherals keep running while idle
// - unmasked request wakes; mask picks vector/resume
// - nonmaskable wake always enters its routine
// - trap carries five bit vector number
// - trap ignores every interrupt mask
// - external vector trap acks, sets mask
module ccf_core
  import ccf_pkg::*;
#(
  parameter int WS = 0,
  parameter int N_IRQ = 6,
  parameter int STACK_DEPTH = 8,
  parameter logic [31:0] EXT_VEC_MASK = 32'h0000007E,
  parameter logic [4:0] NMI_VEC = 5'h12,
  parameter logic [15:0] EXT_BASE = 16'h8000
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins
  input wire logic branch_input_pin_n,
  input wire logic nmi_n,
  input wire logic [N_IRQ-1:0] irq_req,
  output logic irq_ack,
  output logic external_flag_pin_bit,
  output logic power_down,
  // data memory
  output logic [15:0] dmem_addr,
  output logic dmem_rd,
  output logic dmem_wr,
  output logic [15:0] dmem_wdata,
  input wire logic [15:0] dmem_rdata
);
  localparam int SPW = $clog2(STACK_DEPTH);
  // cycle totals including program wait states
  localparam logic [7:0] CYC_CCT = 8'(`CCF_CYC_CC_TAKEN + 4 * WS);
  localparam logic [7:0] CYC_CCN = 8'(`CCF_CYC_CC_NOT + 2 * WS);
  localparam logic [7:0] CYC_TRAP = 8'(`CCF_CYC_TRAP + 3 * WS);
  localparam logic [7:0] CYC_ONE = 8'(`CCF_CYC_ONE + WS);

  // all module state
  typedef struct packed {
    ccf_mode_t mode;
    logic [7:0] cnt;
    logic [15:0] st0;
    logic [15:0] st1;
    logic [15:0] pc;
    logic [15:0] opnd;
    logic [15:0] flush;
    logic [31:0] acc;
    logic [2:0] arp;
    logic [7:0][15:0] ar;
    logic [N_IRQ-1:0] imr;
    logic [N_IRQ-1:0] irq_s1;
    logic [N_IRQ-1:0] irq_s2;
    logic [SPW-1:0] sp;
    logic bio_s1;
    logic bio_s2;
    logic nmi_s1;
    logic nmi_s2;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic ack;
    logic pdn;
    logic [15:0] dm_addr;
    logic [15:0] dm_wdata;
    logic dm_rd;
    logic dm_wr;
  } ccf_core_t;

  ccf_core_t r;
  ccf_core_t n;
  logic [15:0] stack_top; // registered stack top
  logic push; // stack write this cycle
  logic [15:0] push_d; // return address pushed
  ccf_op_t op; // decode of the issued word
  logic wr_go; // apb write commits
  logic issue; // instruction accepted
  logic cc_ok; // call conditions all true
  logic hit; // address is mapped

  // opcode classifier
  function automatic ccf_op_t ccf_decode(input logic [15:0] w);
    ccf_decode = OP_NONE;
    if (w[15:13] == `CCF_OPC_CC_HI) ccf_decode = OP_CC;
    else if (w[15:4] == `CCF_OPC_BIT_CLEAR_OP_HI && !w[0]) ccf_decode = OP_BIT_CLEAR_OP;
    else if (w == `CCF_OPC_INVERT_ACC_OP) ccf_decode = OP_INVERT_ACC_OP;
    else if (w[15:2] == `CCF_OPC_POINTER_COMPARE_OP_HI) ccf_decode = OP_POINTER_COMPARE_OP;
    else if (w == `CCF_OPC_DATA_SHIFT_MOVE_OP) ccf_decode = OP_DATA_SHIFT_MOVE_OP;
    else if (w == `CCF_OPC_IDLE) ccf_decode = OP_IDLE;
    else if (w[15:5] == `CCF_OPC_SOFT_VECTOR_TRAP_HI) ccf_decode = OP_SOFT_VECTOR_TRAP;
  endfunction : ccf_decode

  // and of every selected condition; empty mask means always
  function automatic logic ccf_cond(input logic [12:0] m, input logic [31:0] a, input logic c,
                                    input logic ov, input logic tc, input logic bio_low);
    logic z;
    logic ng;
    logic [12:0] t;
    z = (a == 32'h00000000);
    ng = a[31];
    t = {tc, !tc, bio_low, ov, !ov, c, !c, !ng, !ng && !z, ng || z, ng, !z, z};
    ccf_cond = &(t | ~m);
  endfunction : ccf_cond

  // unsigned pointer compare
  function automatic logic ccf_cmp(input logic [1:0] code, input logic [15:0] a, input logic [15:0] b);
    unique case (code)
      2'b00: ccf_cmp = (a == b);
      2'b01: ccf_cmp = (a < b);
      2'b10: ccf_cmp = (a > b);
      2'b11: ccf_cmp = (a != b);
    endcase
  endfunction : ccf_cmp

  // decode and address check shared with the checks below
  assign hit = (paddr[7:5] == `CCF_AR_BASE_HI) || (paddr <= `CCF_OFF_FLUSH && paddr[1:0] == 2'b00);
  assign wr_go = psel && penable && r.pready && pwrite && hit;
  assign issue = wr_go && paddr == `CCF_OFF_INSTR && r.mode == CCF_RUN;
  assign op = ccf_decode(pwdata[15:0]);
  assign cc_ok = ccf_cond(pwdata[12:0], r.acc, r.st1[`CCF_ST1_C], r.st0[`CCF_ST0_OV],
                          r.st1[`CCF_ST1_TC], !r.bio_s2);

  // next state
  always_comb
  begin
    logic vec_go;
    logic vec_ext;
    logic [4:0] vec_k;
    logic [15:0] ret;
    logic [7:0] lat;
    logic [N_IRQ-1:0] pend;
    n = r;
    vec_go = 1'b0;
    vec_ext = 1'b0;
    vec_k = 5'h00;
    ret = r.pc;
    lat = 8'h00;
    push = 1'b0;
    push_d = 16'h0000;
    // pins pass two flops; first stage feeds only the second
    n.bio_s1 = branch_input_pin_n;
    n.bio_s2 = r.bio_s1;
    n.nmi_s1 = nmi_n;
    n.nmi_s2 = r.nmi_s1;
    n.irq_s1 = irq_req;
    n.irq_s2 = r.irq_s1;
    n.ack = 1'b0;
    n.dm_rd = 1'b0;
    n.dm_wr = 1'b0;
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    pend = r.irq_s2 & r.imr;
    // apb: one wait state so the answer comes from flops
    if (psel && penable && !r.pready)
    begin
      n.pready = 1'b1;
      n.pslverr = !hit;
      n.prdata = 32'h00000000;
      if (paddr[7:5] == `CCF_AR_BASE_HI) n.prdata[15:0] = r.ar[paddr[4:2]];
      else
      begin
        unique case (paddr)
          `CCF_OFF_OPND: n.prdata[15:0] = r.opnd;
          `CCF_OFF_STAT: n.prdata[3:0] = {r.pdn, r.mode != CCF_RUN, r.mode};
          `CCF_OFF_ST0: n.prdata[15:0] = r.st0;
          `CCF_OFF_ST1: n.prdata[15:0] = r.st1;
          `CCF_OFF_ACC: n.prdata = r.acc;
          `CCF_OFF_PC: n.prdata[15:0] = r.pc;
          `CCF_OFF_ARP: n.prdata[2:0] = r.arp;
          `CCF_OFF_IMR: n.prdata[N_IRQ-1:0] = r.imr;
          `CCF_OFF_TOS: n.prdata[15:0] = stack_top;
          `CCF_OFF_FLUSH: n.prdata[15:0] = r.flush;
          default: n.prdata = 32'h00000000;
        endcase
      end
    end
    // register writes commit on the edge that sees pready
    if (wr_go)
    begin
      if (paddr[7:5] == `CCF_AR_BASE_HI) n.ar[paddr[4:2]] = pwdata[15:0];
      else
      begin
        unique case (paddr)
          `CCF_OFF_OPND: n.opnd = pwdata[15:0];
          `CCF_OFF_ST0: n.st0 = pwdata[15:0];
          `CCF_OFF_ST1: n.st1 = pwdata[15:0];
          `CCF_OFF_ACC: n.acc = pwdata;
          `CCF_OFF_PC: n.pc = pwdata[15:0];
          `CCF_OFF_ARP: n.arp = pwdata[2:0];
          `CCF_OFF_IMR: n.imr = pwdata[N_IRQ-1:0];
          default: n.opnd = r.opnd;
        endcase
      end
    end
    unique case (r.mode)
      CCF_RUN:
      begin
        // a word written while not running is dropped
        if (issue)
        begin
          lat = CYC_ONE;
          n.pc = r.pc + 16'h0001;
          unique case (op)
            OP_CC:
            begin
              if (cc_ok)
              begin
                // behaves as a plain call; target comes from the operand word
                ret = r.pc + 16'h0002;
                push = 1'b1;
                push_d = ret;
                n.pc = r.opnd;
                n.flush = r.flush + `CCF_PREFETCH_WORDS;
                lat = CYC_CCT;
              end
              else
              begin
                n.pc = r.pc + 16'h0002;
                lat = CYC_CCN;
              end
            end
            OP_BIT_CLEAR_OP:
            begin
              // unknown selectors clear nothing
              unique case (pwdata[3:0])
                `CCF_SEL_C: n.st1[`CCF_ST1_C] = 1'b0;
                `CCF_SEL_CNF: n.st1[`CCF_ST1_CNF] = 1'b0;
                `CCF_SEL_GLOBAL_IRQ_MASK: n.st0[`CCF_ST0_GLOBAL_IRQ_MASK] = 1'b0;
                `CCF_SEL_OVM: n.st0[`CCF_ST0_OVM] = 1'b0;
                `CCF_SEL_SXM: n.st1[`CCF_ST1_SXM] = 1'b0;
                `CCF_SEL_TC: n.st1[`CCF_ST1_TC] = 1'b0;
                `CCF_SEL_XF: n.st1[`CCF_ST1_XF] = 1'b0;
                default: n.st1 = r.st1;
              endcase
            end
            OP_INVERT_ACC_OP: n.acc = ~r.acc;
            OP_POINTER_COMPARE_OP: n.st1[`CCF_ST1_TC] = ccf_cmp(pwdata[1:0], r.ar[r.arp], r.ar[0]);
            OP_DATA_SHIFT_MOVE_OP:
            begin
              n.dm_rd = 1'b1;
              n.dm_addr = r.opnd;
              n.mode = CCF_DMW;
            end
            OP_IDLE:
            begin
              n.mode = CCF_IDLE;
              n.pdn = 1'b1;
            end
            OP_SOFT_VECTOR_TRAP:
            begin
              // no mask is looked at here
              vec_go = 1'b1;
              vec_k = pwdata[4:0];
              vec_ext = EXT_VEC_MASK[pwdata[4:0]];
              ret = r.pc + 16'h0001;
              lat = CYC_TRAP;
            end
            default: n.pc = r.pc + 16'h0001;
          endcase
        end
      end
      CCF_BUSY:
      begin
        n.cnt = r.cnt - 8'h01;
        if (r.cnt == 8'h01) n.mode = CCF_RUN;
      end
      CCF_IDLE:
      begin
        // pc frozen; sync stages and mask keep running so requests can wake
        if (!r.nmi_s2)
        begin
          vec_go = 1'b1;
          vec_k = NMI_VEC;
          vec_ext = 1'b1;
        end
        else if (|pend)
        begin
          if (!r.st0[`CCF_ST0_GLOBAL_IRQ_MASK])
          begin
            vec_go = 1'b1;
            vec_ext = 1'b1;
            for (int i = N_IRQ - 1; i >= 0; i--)
            begin
              if (pend[i]) vec_k = 5'(i + 1);
            end
          end
          n.mode = CCF_RUN;
          n.pdn = 1'b0;
        end
        if (vec_go)
        begin
          n.mode = CCF_RUN;
          n.pdn = 1'b0;
        end
      end
      CCF_DMW:
      begin
        // copy to next word only inside internal memory
        if (r.dm_addr < EXT_BASE)
        begin
          n.dm_wr = 1'b1;
          n.dm_addr = r.dm_addr + 16'h0001;
          n.dm_wdata = dmem_rdata;
        end
        n.mode = CCF_RUN;
      end
    endcase
    // vector entry shared by trap and wake
    if (vec_go)
    begin
      push = 1'b1;
      push_d = ret;
      n.pc = {10'h000, vec_k, 1'b0};
      n.flush = r.flush + `CCF_PREFETCH_WORDS;
      if (vec_ext)
      begin
        n.ack = 1'b1;
        n.st0[`CCF_ST0_GLOBAL_IRQ_MASK] = 1'b1;
      end
    end
    if (push) n.sp = r.sp + SPW'(1);
    if (lat > 8'h01)
    begin
      n.mode = CCF_BUSY;
      n.cnt = lat - 8'h01;
    end
  end

  // state register; reset acts as wake and enters the reset vector
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r <= '0;
      r.mode <= CCF_RUN;
      r.st0 <= `CCF_ST0_RST;
      r.st1 <= `CCF_ST1_RST;
      r.pc <= `CCF_PC_RST;
      r.bio_s1 <= 1'b1;
      r.bio_s2 <= 1'b1;
      r.nmi_s1 <= 1'b1;
      r.nmi_s2 <= 1'b1;
    end
    else
    begin
      r <= n;
    end
  end

  // return stack, shared by every call kind
  ccf_stack_mem #(.DEPTH(STACK_DEPTH), .AW(SPW)) u_stack (
    .clk(pclk),
    .rst_n(presetn),
    .wr_en(push),
    .wr_addr(r.sp),
    .wr_data(push_d),
    .rd_addr(r.sp - SPW'(1)),
    .rd_data_r(stack_top)
  );

  // outputs straight from flops
  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign irq_ack = r.ack;
  assign external_flag_pin_bit = r.st1[`CCF_ST1_XF];
  assign power_down = r.pdn;
  assign dmem_addr = r.dm_addr;
  assign dmem_rd = r.dm_rd;
  assign dmem_wr = r.dm_wr;
  assign dmem_wdata = r.dm_wdata;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_busy3;
    (r.mode == CCF_BUSY) [*3] ##1 (r.mode == CCF_RUN);
  endsequence

  a_cc_taken_jump: assert property (issue && op == OP_CC && cc_ok |=> r.pc == $past(r.opnd) && push == 1'b0)
    else $error("taken call did not load target");
  a_cc_skip_pc: assert property (issue && op == OP_CC && !cc_ok |=> r.pc == $past(r.pc) + 16'h0002)
    else $error("untaken call pc wrong");
  a_cc_taken_len: assert property (WS == 0 && issue && op == OP_CC && cc_ok |=> s_busy3)
    else $error("taken call length wrong");
  a_cc_skip_len: assert property (WS == 0 && issue && op == OP_CC && !cc_ok |=> r.mode == CCF_BUSY ##1 r.mode == CCF_RUN)
    else $error("untaken call length wrong");
  a_bit_clear_op_tc_only: assert property (issue && op == OP_BIT_CLEAR_OP && pwdata[3:0] == `CCF_SEL_TC
    |=> !r.st1[`CCF_ST1_TC] && r.st0 == $past(r.st0) && r.mode == CCF_RUN)
    else $error("clear touched wrong bits");
  a_invert_acc_op_invert: assert property (issue && op == OP_INVERT_ACC_OP |=> r.acc == ~$past(r.acc) && r.st1 == $past(r.st1))
    else $error("inversion wrong");
  a_pointer_compare_op_result: assert property (issue && op == OP_POINTER_COMPARE_OP
    |=> r.st1[`CCF_ST1_TC] == ccf_cmp($past(pwdata[1:0]), $past(r.ar[r.arp]), $past(r.ar[0]))
    && r.st1[`CCF_ST1_SXM] == $past(r.st1[`CCF_ST1_SXM]))
    else $error("compare result wrong");
  a_idle_freeze: assert property (r.mode == CCF_IDLE && r.nmi_s2 && !(|(r.irq_s2 & r.imr)) && !wr_go
    |=> r.pc == $past(r.pc) && r.mode == CCF_IDLE)
    else $error("pc moved in idle");
  a_idle_nmi_vec: assert property (r.mode == CCF_IDLE && !r.nmi_s2 |=> r.pc == {10'h000, NMI_VEC, 1'b0} && r.ack)
    else $error("nmi wake missed vector");
  a_soft_vector_trap_vector: assert property (issue && op == OP_SOFT_VECTOR_TRAP
    |=> r.pc == {10'h000, $past(pwdata[4:0]), 1'b0} && r.sp == $past(r.sp) + SPW'(1))
    else $error("trap vector wrong");
  a_soft_vector_trap_ext_ack: assert property (issue && op == OP_SOFT_VECTOR_TRAP && EXT_VEC_MASK[pwdata[4:0]]
    |=> r.ack && r.st0[`CCF_ST0_GLOBAL_IRQ_MASK])
    else $error("external trap did not ack");
  a_data_shift_move_op_ext_read: assert property (r.mode == CCF_DMW && r.dm_addr >= EXT_BASE |=> !r.dm_wr)
    else $error("external move wrote");
endmodule : ccf_core

// ==== design/ccf_stack_mem.sv ====
`timescale 1ns/1ps
// return stack storage; read data registered
module ccf_stack_mem #(
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // push side
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [15:0] wr_data,
  // read side
  input wire logic [AW-1:0] rd_addr,
  output logic [15:0] rd_data_r
);
  // storage carries no reset; only the read register does
  logic [15:0] mem [DEPTH];

  // write port
  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  // registered read port
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_data_r <= 16'h0000;
    end
    else
    begin
      rd_data_r <= mem[rd_addr];
    end
  end
endmodule : ccf_stack_mem

// ==== inc/ccf_map.svh ====
`ifndef CCF_MAP_SVH
`define CCF_MAP_SVH
// apb byte offsets
`define CCF_OFF_INSTR 8'h00
`define CCF_OFF_OPND 8'h04
`define CCF_OFF_STAT 8'h08
`define CCF_OFF_ST0 8'h0C
`define CCF_OFF_ST1 8'h10
`define CCF_OFF_ACC 8'h14
`define CCF_OFF_PC 8'h18
`define CCF_OFF_ARP 8'h1C
`define CCF_OFF_IMR 8'h20
`define CCF_OFF_TOS 8'h24
`define CCF_OFF_FLUSH 8'h28
`define CCF_AR_BASE_HI 3'h2
// status word zero bit positions
`define CCF_ST0_OV 12
`define CCF_ST0_OVM 11
`define CCF_ST0_GLOBAL_IRQ_MASK 9
// status word one bit positions
`define CCF_ST1_CNF 12
`define CCF_ST1_TC 11
`define CCF_ST1_SXM 10
`define CCF_ST1_C 9
`define CCF_ST1_XF 4
// reset values
`define CCF_ST0_RST 16'h0200
`define CCF_ST1_RST 16'h0000
`define CCF_PC_RST 16'h0000
// opcode patterns
`define CCF_OPC_BIT_CLEAR_OP_HI 12'hBE4
`define CCF_OPC_INVERT_ACC_OP 16'hBE01
`define CCF_OPC_IDLE 16'hBE22
`define CCF_OPC_POINTER_COMPARE_OP_HI 14'h2FD1
`define CCF_OPC_SOFT_VECTOR_TRAP_HI 11'h5F3
`define CCF_OPC_CC_HI 3'h7
`define CCF_OPC_DATA_SHIFT_MOVE_OP 16'h7700
// clear-bit selectors in opcode bits 3:0
`define CCF_SEL_C 4'hE
`define CCF_SEL_CNF 4'h4
`define CCF_SEL_GLOBAL_IRQ_MASK 4'h0
`define CCF_SEL_OVM 4'h2
`define CCF_SEL_SXM 4'h6
`define CCF_SEL_TC 4'hA
`define CCF_SEL_XF 4'hC
// cycle counts
`define CCF_CYC_CC_TAKEN 4
`define CCF_CYC_CC_NOT 2
`define CCF_CYC_TRAP 4
`define CCF_CYC_ONE 1
`define CCF_PREFETCH_WORDS 16'h0002
`endif

// ==== inc/ccf_pkg.sv ====
package ccf_pkg;
  // core execution modes
  typedef enum logic [1:0] {CCF_RUN, CCF_BUSY, CCF_IDLE, CCF_DMW} ccf_mode_t;
  // decoded operations
  typedef enum logic [2:0] {OP_NONE, OP_CC, OP_BIT_CLEAR_OP, OP_INVERT_ACC_OP, OP_POINTER_COMPARE_OP, OP_DATA_SHIFT_MOVE_OP, OP_IDLE, OP_SOFT_VECTOR_TRAP} ccf_op_t;
endpackage : ccf_pkg

// ==== test/ccf_dmem_model.sv ====
`timescale 1ns/1ps
// far side data memory; read data stands in the same cycle as the read strobe,
// since the core captures it at the edge that ends that strobe
module ccf_dmem_model (
  // clock
  input wire logic pclk,
  // memory bus
  input wire logic [15:0] dmem_addr,
  input wire logic dmem_rd,
  input wire logic dmem_wr,
  input wire logic [15:0] dmem_wdata,
  output logic [15:0] dmem_rdata
);
  logic [15:0] mem [int]; // sparse storage, bench preloads it
  int n_wr = 0; // writes seen, lets the bench spot stray copies
  logic [15:0] spin = 16'h0000; // moving junk for an idle bus
  // store writes
  always @(posedge pclk)
  begin
    spin <= spin + 16'h3C5B;
    if (dmem_wr)
    begin
      mem[int'(dmem_addr)] = dmem_wdata;
      n_wr++;
    end
  end
  // read answers while the strobe stands; otherwise junk, never a stale word
  always @*
  begin
    if (dmem_rd)
      dmem_rdata = mem.exists(int'(dmem_addr)) ? mem[int'(dmem_addr)] : 16'h0000;
    else
      dmem_rdata = ~dmem_addr ^ spin;
  end
endmodule : ccf_dmem_model

// ==== test/tb.sv ====
`timescale 1ns/1ps
`include "ccf_map.svh"
// self-checking bench for the flow and flag ops
module tb;
  localparam logic [31:0] EXT_VECS = 32'h0000007E; // vectors that act as external lines
  localparam logic [4:0] NMI_V = 5'h12;
  // one conditional call case
  typedef struct packed {
    logic [31:0] acc;
    logic [15:0] s0;
    logic [15:0] s1;
    logic pin_n;
    logic [12:0] cond;
    logic tk;
  } ccf_cc_case_t;
  // pin and flag tests never share one case
  localparam ccf_cc_case_t CC_TBL [11] = '{
    '{32'h0, 16'h0200, 16'h0200, 1'b1, 13'h0088, 1'b1},
    '{32'h0, 16'h0200, 16'h0000, 1'b1, 13'h0088, 1'b0},
    '{32'h80000000, 16'h0200, 16'h0000, 1'b1, 13'h0004, 1'b1},
    '{32'h5, 16'h1200, 16'h0000, 1'b1, 13'h0110, 1'b0},
    '{32'h5, 16'h1200, 16'h0000, 1'b1, 13'h0222, 1'b1},
    '{32'h0, 16'h0200, 16'h0000, 1'b1, 13'h0041, 1'b1},
    '{32'h0, 16'h0200, 16'h0000, 1'b0, 13'h0400, 1'b1},
    '{32'h0, 16'h0200, 16'h0000, 1'b1, 13'h0400, 1'b0},
    '{32'h0, 16'h0200, 16'h0800, 1'b1, 13'h0800, 1'b0},
    '{32'h0, 16'h0200, 16'h0800, 1'b1, 13'h1000, 1'b1},
    '{32'h1, 16'h0200, 16'h0000, 1'b1, 13'h0000, 1'b1}
  };
  // clock, reset and apb
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic pready, pslverr, last_err;
  // pins and memory bus
  logic bpin_n = 1'b1, nmi_n = 1'b1, irq_ack, xf_pin, power_down;
  logic [5:0] irq_req = 6'h00;
  logic [15:0] dmem_addr, dmem_wdata, dmem_rdata;
  logic dmem_rd, dmem_wr;
  int n_mismatch = 0, n_checks = 0, n_ack = 0, cyc = 0;

  ccf_core #(.EXT_VEC_MASK(EXT_VECS), .NMI_VEC(NMI_V)) DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .branch_input_pin_n(bpin_n), .nmi_n(nmi_n), .irq_req(irq_req),
    .irq_ack(irq_ack), .external_flag_pin_bit(xf_pin), .power_down(power_down), .dmem_addr(dmem_addr),
    .dmem_rd(dmem_rd), .dmem_wr(dmem_wr), .dmem_wdata(dmem_wdata), .dmem_rdata(dmem_rdata));
  ccf_dmem_model mem_i (.pclk(pclk), .dmem_addr(dmem_addr), .dmem_rd(dmem_rd), .dmem_wr(dmem_wr),
    .dmem_wdata(dmem_wdata), .dmem_rdata(dmem_rdata));

  // 10 MHz clock
  initial
  begin
    forever #50 pclk = ~pclk;
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test

  // count acknowledges; cut a hang short
  always @(posedge pclk)
  begin
    cyc++;
    if (irq_ack === 1'b1)
      n_ack++;
    if (cyc == 40000)
    begin
      n_mismatch++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask : chk

  // one apb transfer; waits an edge first so no signal is driven twice in a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 40);
    chk(n < 40, 1'b1, "apb answer lost");
    rdv = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string m);
    rd(a);
    chk(rdv, e, m);
  endtask : rchk

  // issue one opcode, then let the longest busy spell pass
  task automatic op(input logic [15:0] x);
    wr(`CCF_OFF_INSTR, {16'h0, x});
    repeat (4) @(posedge pclk);
  endtask : op

  // wait for the core to leave power down, bounded
  task automatic wake;
    for (int n = 0; n < 30 && power_down !== 1'b0; n++)
      @(posedge pclk);
    chk(power_down, 1'b0, "no wake");
  endtask : wake

  task automatic t_reset;
    rchk(`CCF_OFF_ST0, 32'h0200, "word zero reset");
    rchk(`CCF_OFF_ST1, 32'h0, "word one reset");
    rchk(8'h3C, 32'h0, "unmapped read");
    chk(last_err, 1'b1, "unmapped error");
  endtask : t_reset

  task automatic t_clear;
    logic [3:0] sel [7] = '{`CCF_SEL_C, `CCF_SEL_CNF, `CCF_SEL_GLOBAL_IRQ_MASK, `CCF_SEL_OVM, `CCF_SEL_SXM,
      `CCF_SEL_TC, `CCF_SEL_XF};
    int pos [7] = '{9, 12, 9, 11, 10, 11, 4};
    bit one [7] = '{1, 1, 0, 0, 1, 1, 1};
    logic [15:0] e0, e1;
    for (int i = 0; i < 7; i++)
    begin
      wr(`CCF_OFF_ST0, 32'h0A00);
      wr(`CCF_OFF_ST1, 32'h1E10);
      e0 = 16'h0A00;
      e1 = 16'h1E10;
      // only the chosen bit drops
      if (one[i])
        e1[pos[i]] = 1'b0;
      else
        e0[pos[i]] = 1'b0;
      op({12'hBE4, sel[i]});
      rchk(`CCF_OFF_ST0, {16'h0, e0}, "clear word zero");
      rchk(`CCF_OFF_ST1, {16'h0, e1}, "clear word one");
      chk(xf_pin, e1[4], "flag pin");
    end
  endtask : t_clear

  task automatic t_invert;
    wr(`CCF_OFF_ACC, 32'h12345678);
    wr(`CCF_OFF_ST0, 32'h1A00);
    wr(`CCF_OFF_ST1, 32'h0200);
    op(16'hBE01);
    rchk(`CCF_OFF_ACC, 32'hEDCBA987, "inverted acc");
    rchk(`CCF_OFF_ST1, 32'h0200, "carry kept");
    rchk(`CCF_OFF_ST0, 32'h1A00, "flags kept");
  endtask : t_invert

  // signed reading of the 7FFF pair would flip less and greater
  task automatic t_compare;
    logic [15:0] ar [3] = '{16'h7FFF, 16'hFFFF, 16'h8000};
    logic tc;
    wr(8'h40, 32'h00008000);
    wr(`CCF_OFF_ARP, 32'h4);
    wr(`CCF_OFF_ST1, 32'h0400);
    for (int j = 0; j < 3; j++)
    begin
      wr(8'h50, {16'h0, ar[j]});
      for (int cm = 0; cm < 4; cm++)
      begin
        case (cm)
          0: tc = ar[j] == 16'h8000;
          1: tc = ar[j] < 16'h8000;
          2: tc = ar[j] > 16'h8000;
          default: tc = ar[j] != 16'h8000;
        endcase
        op(16'hBF44 | 16'(cm));
        rchk(`CCF_OFF_ST1, 32'h0400 | (32'(tc) << 11), "compare flag");
      end
    end
  endtask : t_compare

  task automatic t_call;
    ccf_cc_case_t c;
    logic [31:0] p, f;
    for (int i = 0; i < 11; i++)
    begin
      c = CC_TBL[i];
      bpin_n <= c.pin_n;
      wr(`CCF_OFF_ACC, c.acc);
      wr(`CCF_OFF_ST0, {16'h0, c.s0});
      wr(`CCF_OFF_ST1, {16'h0, c.s1});
      wr(`CCF_OFF_OPND, 32'h0300 + i);
      rd(`CCF_OFF_PC);
      p = rdv;
      rd(`CCF_OFF_FLUSH);
      f = rdv;
      op({3'h7, c.cond});
      rchk(`CCF_OFF_PC, c.tk ? 32'h0300 + i : (p + 2) & 32'hFFFF, "call target");
      rchk(`CCF_OFF_FLUSH, c.tk ? f + 2 : f, "prefetch discard");
      if (c.tk)
        rchk(`CCF_OFF_TOS, (p + 2) & 32'hFFFF, "call return");
    end
    bpin_n <= 1'b1;
  endtask : t_call

  task automatic t_move;
    int n;
    mem_i.mem[32'h0100] = 16'h5A5A;
    mem_i.mem[32'h0101] = 16'h0000;
    mem_i.mem[32'h8100] = 16'h1234;
    mem_i.mem[32'h8101] = 16'h0000;
    wr(`CCF_OFF_OPND, 32'h0100);
    op(16'h7700);
    chk(mem_i.mem[32'h0101], 32'h5A5A, "copy to next");
    n = mem_i.n_wr;
    wr(`CCF_OFF_OPND, 32'h8100);
    op(16'h7700);
    chk(mem_i.n_wr, n, "external move wrote");
    chk(mem_i.mem[32'h8101], 32'h0, "external next word");
  endtask : t_move

  task automatic t_idle;
    logic [31:0] p;
    int a;
    wr(`CCF_OFF_ST0, 32'h0200);
    wr(`CCF_OFF_IMR, 32'h0);
    rd(`CCF_OFF_PC);
    p = rdv;
    op(16'hBE22);
    chk(power_down, 1'b1, "asleep");
    irq_req <= 6'h01;
    repeat (20) @(posedge pclk);
    chk(power_down, 1'b1, "masked line woke");
    rchk(`CCF_OFF_PC, (p + 1) & 32'hFFFF, "pc held");
    // enabling the line lets the pending request in, mask still set
    wr(`CCF_OFF_IMR, 32'h1);
    wake();
    rchk(`CCF_OFF_PC, (p + 1) & 32'hFFFF, "resume after idle");
    irq_req <= 6'h00;
    wr(`CCF_OFF_ST0, 32'h0);
    wr(`CCF_OFF_IMR, 32'h2);
    rd(`CCF_OFF_PC);
    p = rdv;
    a = n_ack;
    op(16'hBE22);
    irq_req <= 6'h03;
    wake();
    rchk(`CCF_OFF_PC, 32'h4, "irq vector");
    irq_req <= 6'h00;
    rchk(`CCF_OFF_TOS, (p + 1) & 32'hFFFF, "irq return");
    rchk(`CCF_OFF_ST0, 32'h0200, "irq sets mask");
    chk(n_ack - a, 32'h1, "irq ack");
    // mask is set now, the nonmaskable line must still enter
    a = n_ack;
    op(16'hBE22);
    nmi_n <= 1'b0;
    wake();
    rchk(`CCF_OFF_PC, {26'h0, NMI_V, 1'b0}, "nmi vector");
    nmi_n <= 1'b1;
    rchk(`CCF_OFF_TOS, 32'h5, "nmi return");
    chk(n_ack - a, 32'h1, "nmi ack");
  endtask : t_idle

  task automatic t_trap;
    logic [31:0] p;
    logic [15:0] s0;
    int a;
    wr(`CCF_OFF_IMR, 32'h0);
    for (int k = 0; k < 32; k++)
    begin
      s0 = k[0] ? 16'h0200 : 16'h0000;
      wr(`CCF_OFF_ST0, {16'h0, s0});
      rd(`CCF_OFF_PC);
      p = rdv;
      a = n_ack;
      op(16'hBE60 | 16'(k));
      rchk(`CCF_OFF_PC, 32'(2 * k), "trap vector");
      rchk(`CCF_OFF_TOS, (p + 1) & 32'hFFFF, "trap return");
      rchk(`CCF_OFF_ST0, EXT_VECS[k] ? 32'h0200 : {16'h0, s0}, "trap mask");
      chk(n_ack - a, 32'(EXT_VECS[k]), "trap ack");
    end
  endtask : t_trap

  // main sequence
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_clear();
    t_invert();
    t_compare();
    t_call();
    t_move();
    t_idle();
    t_trap();
    finish_test();
  end
endmodule : tb
